// ### src/i2c_flag_cfg.svh
/*
  constants for the i2c status-flag block: register indexes, bit positions,
  reset values. assumes inclusion by bare name from the design files.
*/
`ifndef I2C_FLAG_CFG_SVH
`define I2C_FLAG_CFG_SVH
// ************************************************************
// register indexes (byte address = 4 * index)
// ************************************************************
`define CTRL_ONE_IDX 4'h2
`define STATUS_IDX 4'h3
`define DATA_IDX 4'h4
`define RANGE_ADDR_IDX 4'h5
`define PRIMARY_ADDR_IDX 4'h6
`define SECOND_ADDR_IDX 4'h7
`define ENABLES_IDX 4'h8
`define IRQ_STATUS_IDX 4'h9
`define IRQ_MASK_IDX 4'ha
// ************************************************************
// status bit positions
// ************************************************************
`define ST_DONE_BIT 7
`define ST_AAS_BIT 6
`define ST_BUSY_BIT 5
`define ST_ARB_BIT 4
`define ST_RANGE_BIT 3
`define ST_DIR_BIT 2
// ************************************************************
// enables register bits and the control-one transmit bit
// ************************************************************
`define EN_RANGE_BIT 0
`define EN_GCALL_BIT 1
`define EN_SECOND_BIT 2
`define EN_ALERT_BIT 3
`define CTRL_TX_BIT 4
// ************************************************************
// fixed addresses, reset values and interrupt bits
// ************************************************************
`define GCALL_ADDR 7'h00
`define ALERT_ADDR 7'h0c
`define BYTE_RESET 8'h00
`define IRQ_BITS 4
`define IRQ_DONE 0
`define IRQ_ADDRESSED 1
`define IRQ_ARB 2
`define IRQ_RANGE 3
`endif

// ### src/i2c_flag_pkg.sv
/*
  types for the i2c status-flag block.
  assumes the cfg header holds all numbers.
*/
package i2c_flag_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [6:0] addr7_t;
endpackage

// ### src/i2c_addr_match.sv
/*
  calling-address comparator for the status-flag block.
  assumes a captured 7-bit address and register values on the same clock.
*/
`timescale 1ns/100ps
`include "i2c_flag_cfg.svh"
module i2c_addr_match (
  input wire i2c_flag_pkg::addr7_t call_addr,
  input wire i2c_flag_pkg::addr7_t primary_addr,
  input wire i2c_flag_pkg::addr7_t second_addr,
  input wire i2c_flag_pkg::addr7_t range_addr,
  input wire logic range_en,
  input wire logic gcall_en,
  input wire logic second_en,
  input wire logic alert_en,
  output logic any_match,
  output logic range_hit
);
  // ************************************************************
  // comparisons
  // ************************************************************
  logic in_span;
  logic range_eq;
  always_comb begin
    // span is inclusive and works whichever bound is larger
    in_span = (call_addr >= primary_addr && call_addr <= range_addr) ||
              (call_addr <= primary_addr && call_addr >= range_addr);
    range_eq = (range_addr != 7'h00) && (call_addr == range_addr);
    range_hit = range_en && (call_addr != 7'h00) && (range_eq || in_span);
    any_match = (call_addr == primary_addr)
             || range_hit
             || (gcall_en && call_addr == `GCALL_ADDR)
             || (second_en && call_addr == second_addr)
             || (alert_en && call_addr == `ALERT_ADDR);
  end
endmodule

// ### src/i2c_status_flag_logic.sv
/*
  status-flag logic of an i2c controller: transfer done, addressed as slave,
  bus busy, arbitration lost, range match, slave direction, plus interrupt.
  assumes bus events come as one-cycle pulses from a shifter on clk, and
  that software reaches the registers over a plain strobe port.
*/
// Implementation choice: the strobed register port.
// Contract
// - set transfer-done at byte end, else 0
// - clear transfer-done on data read rx/write tx
// - addressed on primary address match
// - addressed on nonzero range register match if enabled
// - addressed on general call if enabled
// - addressed on second address if enabled
// - addressed on alert response if enabled
// - addressed on primary-to-range span if enabled
// - addressed flag set before ack bit
// - any control-one write clears addressed flag
// - busy set on start, cleared on stop
// - set arbitration-lost on lost arbitration
// - arbitration-lost stays until one written
// - range-match flag set on range hit, cleared
// - report received read/write bit, 0 = write
`timescale 1ns/100ps
`include "i2c_flag_cfg.svh"
module i2c_status_flag_logic (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic byte_done,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic arb_lost,
  input wire logic [7:0] rx_data,
  output logic [7:0] tx_data,
  output logic tx_load,
  output logic addressed,
  output logic irq
);
  // ************************************************************
  // software access decode
  // ************************************************************
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx, input logic stb);
    hit = stb && (a == idx);
  endfunction

  logic wr_ctrl;
  logic wr_status;
  logic wr_data;
  logic rd_data;
  logic tx_mode;
  logic [7:0] ctrl_q;
  logic [7:0] enables_q;
  i2c_flag_pkg::addr7_t primary_q;
  i2c_flag_pkg::addr7_t second_q;
  i2c_flag_pkg::addr7_t range_q;
  logic [`IRQ_BITS-1:0] irq_stat_q;
  logic [`IRQ_BITS-1:0] irq_mask_q;
  logic done_q;
  logic aas_q;
  logic busy_q;
  logic arb_q;
  logic range_flag_q;
  logic dir_q;
  logic match;
  logic range_hit;

  assign wr_ctrl = hit(addr, `CTRL_ONE_IDX, wr_stb);
  assign wr_status = hit(addr, `STATUS_IDX, wr_stb);
  assign wr_data = hit(addr, `DATA_IDX, wr_stb);
  assign rd_data = hit(addr, `DATA_IDX, rd_stb);
  assign tx_mode = ctrl_q[`CTRL_TX_BIT];

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `BYTE_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enables_q <= `BYTE_RESET;
      primary_q <= 7'h00;
      second_q <= 7'h00;
      range_q <= 7'h00;
      irq_mask_q <= '0;
    end else if (wr_stb) begin
      if (addr == `ENABLES_IDX) begin
        enables_q <= wdata;
      end
      if (addr == `PRIMARY_ADDR_IDX) begin
        primary_q <= wdata[7:1];
      end
      if (addr == `SECOND_ADDR_IDX) begin
        second_q <= wdata[7:1];
      end
      if (addr == `RANGE_ADDR_IDX) begin
        range_q <= wdata[7:1];
      end
      if (addr == `IRQ_MASK_IDX) begin
        irq_mask_q <= wdata[`IRQ_BITS-1:0];
      end
    end
  end

  // ************************************************************
  // transmit data handoff
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data <= `BYTE_RESET;
    end else if (wr_data) begin
      tx_data <= wdata;
    end
  end
  assign tx_load = wr_data && tx_mode;

  // ************************************************************
  // address comparison
  // ************************************************************
  i2c_addr_match i2c_addr_match_inst (
    .call_addr(addr_byte[7:1]),
    .primary_addr(primary_q),
    .second_addr(second_q),
    .range_addr(range_q),
    .range_en(enables_q[`EN_RANGE_BIT]),
    .gcall_en(enables_q[`EN_GCALL_BIT]),
    .second_en(enables_q[`EN_SECOND_BIT]),
    .alert_en(enables_q[`EN_ALERT_BIT]),
    .any_match(match),
    .range_hit(range_hit)
  );

  // ************************************************************
  // status flags; a set in the same cycle as a clear wins
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (byte_done) begin
      done_q <= 1'b1;
    end else if ((rd_data && !tx_mode) || (wr_data && tx_mode)) begin
      done_q <= 1'b0;
    end
  end

  // addr_valid comes from the shifter before the ack bit, so the flag
  // is up one cycle later, still ahead of the ack phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aas_q <= 1'b0;
    end else if (addr_valid && match) begin
      aas_q <= 1'b1;
    end else if (wr_ctrl) begin
      aas_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      range_flag_q <= 1'b0;
    end else if (addr_valid && range_hit) begin
      range_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      range_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_q <= 1'b0;
    end else if (addr_valid && match) begin
      dir_q <= addr_byte[0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
    end else if (start_det) begin
      busy_q <= 1'b1;
    end else if (stop_det) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arb_q <= 1'b0;
    end else if (arb_lost) begin
      arb_q <= 1'b1;
    end else if (wr_status && wdata[`ST_ARB_BIT]) begin
      arb_q <= 1'b0;
    end
  end

  // ************************************************************
  // interrupt status, write one to clear
  // ************************************************************
  logic [`IRQ_BITS-1:0] irq_ev;
  always_comb begin
    irq_ev = '0;
    irq_ev[`IRQ_DONE] = byte_done;
    irq_ev[`IRQ_ADDRESSED] = addr_valid && match;
    irq_ev[`IRQ_ARB] = arb_lost;
    irq_ev[`IRQ_RANGE] = addr_valid && range_hit;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= '0;
    end else if (hit(addr, `IRQ_STATUS_IDX, wr_stb)) begin
      irq_stat_q <= (irq_stat_q & ~wdata[`IRQ_BITS-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);
  assign addressed = aas_q;

  // ************************************************************
  // read path; only arbitration-lost takes status writes
  // ************************************************************
  logic [7:0] status_v;
  logic [7:0] rd_d;
  always_comb begin
    status_v = `BYTE_RESET;
    status_v[`ST_DONE_BIT] = done_q;
    status_v[`ST_AAS_BIT] = aas_q;
    status_v[`ST_BUSY_BIT] = busy_q;
    status_v[`ST_ARB_BIT] = arb_q;
    status_v[`ST_RANGE_BIT] = range_flag_q;
    status_v[`ST_DIR_BIT] = dir_q;
    rd_d = `BYTE_RESET;
    unique case (addr)
      `CTRL_ONE_IDX: rd_d = ctrl_q;
      `STATUS_IDX: rd_d = status_v;
      `DATA_IDX: rd_d = rx_data;
      `RANGE_ADDR_IDX: rd_d = {range_q, 1'b0};
      `PRIMARY_ADDR_IDX: rd_d = {primary_q, 1'b0};
      `SECOND_ADDR_IDX: rd_d = {second_q, 1'b0};
      `ENABLES_IDX: rd_d = enables_q;
      `IRQ_STATUS_IDX: rd_d = {{(8-`IRQ_BITS){1'b0}}, irq_stat_q};
      `IRQ_MASK_IDX: rd_d = {{(8-`IRQ_BITS){1'b0}}, irq_mask_q};
      default: rd_d = `BYTE_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `BYTE_RESET;
    end else if (rd_stb) begin
      rdata <= rd_d;
    end else begin
      rdata <= `BYTE_RESET;
    end
  end
endmodule

// ### sim/i2c_flag_sva.sv
/*
  checker for the status-flag block, bound to its ports.
  assumes register indexes and bit positions of the cfg header.
*/
`timescale 1ns/100ps
`include "i2c_flag_cfg.svh"
module flag_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic byte_done,
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic arb_lost,
  input wire logic [7:0] tx_data,
  input wire logic tx_load,
  input wire logic addressed
);
  // ****************
  // shadow flags
  // ****************
  logic busy_q, arb_q, done_q, tx_q;
  logic [6:0] prim_q;
  logic st_wr, st_rd, ctl_wr, dat_wr, dat_rd;
  assign st_wr = wr_stb && addr == `STATUS_IDX;
  assign st_rd = rd_stb && addr == `STATUS_IDX;
  assign ctl_wr = wr_stb && addr == `CTRL_ONE_IDX;
  assign dat_wr = wr_stb && addr == `DATA_IDX;
  assign dat_rd = rd_stb && addr == `DATA_IDX;
  // set wins over a clear in the same cycle, as the design does
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'h0;
      arb_q <= 1'h0;
      done_q <= 1'h0;
      tx_q <= 1'h0;
      prim_q <= 7'h00;
    end else begin
      busy_q <= start_det | (busy_q & ~stop_det);
      arb_q <= arb_lost | (arb_q & ~(st_wr & wdata[`ST_ARB_BIT]));
      done_q <= byte_done | (done_q & ~((dat_rd & ~tx_q) | (dat_wr & tx_q)));
      tx_q <= ctl_wr ? wdata[`CTRL_TX_BIT] : tx_q;
      if (wr_stb && addr == `PRIMARY_ADDR_IDX) begin
        prim_q <= wdata[7:1];
      end
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_prim;
    addr_valid && addr_byte[7:1] == prim_q |=> addressed;
  endproperty
  a_prim: assert property (p_prim) else $error("primary match not flagged");
  property p_ctl_clr;
    ctl_wr && !addr_valid |=> !addressed;
  endproperty
  a_ctl_clr: assert property (p_ctl_clr) else $error("addressed kept");
  property p_busy;
    st_rd |=> rdata[`ST_BUSY_BIT] == $past(busy_q);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");
  property p_arb;
    st_rd |=> rdata[`ST_ARB_BIT] == $past(arb_q);
  endproperty
  a_arb: assert property (p_arb) else $error("arb bit wrong");
  property p_done;
    st_rd |=> rdata[`ST_DONE_BIT] == $past(done_q);
  endproperty
  a_done: assert property (p_done) else $error("done bit wrong");
  property p_tx_load;
    dat_wr |-> tx_load == tx_q ##1 tx_data == $past(wdata);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("data write wrong");
  property p_ro;
    st_wr && !addr_valid |=> $stable(addressed);
  endproperty
  a_ro: assert property (p_ro) else $error("status write moved flag");
  property p_rd_idle;
    !rd_stb |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  c_addr: cover property (addr_valid ##1 addressed);
  c_arb: cover property (arb_lost ##1 !arb_lost);
  c_frame: cover property (start_det ##[1:200] stop_det);
endmodule
bind i2c_status_flag_logic flag_sva flag_sva_inst (.clk(clk), .arst_n(arst_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .byte_done(byte_done), .addr_valid(addr_valid), .addr_byte(addr_byte),
  .start_det(start_det), .stop_det(stop_det), .arb_lost(arb_lost),
  .tx_data(tx_data), .tx_load(tx_load), .addressed(addressed));

// ### sim/bus_side.sv
/*
  far side: the bus as seen through the shifter, one pulse per event.
  assumes one caller at a time; gap slows every event.
*/
`timescale 1ns/100ps
module bus_side (
  input wire logic clk,
  output logic byte_done,
  output logic addr_valid,
  output logic [7:0] addr_byte,
  output logic start_det,
  output logic stop_det,
  output logic arb_lost,
  output logic [7:0] rx_data
);
  int gap = 0;
  initial begin
    {byte_done, addr_valid, start_det, stop_det, arb_lost} = 5'h00;
    addr_byte = 8'h00;
    rx_data = 8'h00;
  end
  // address is handed over before the ack slot
  task frame(input logic [7:0] ab);
    repeat (gap + 1) @(posedge clk);
    start_det <= 1'h1;
    @(posedge clk);
    start_det <= 1'h0;
    addr_valid <= 1'h1;
    addr_byte <= ab;
    @(posedge clk);
    addr_valid <= 1'h0;
    addr_byte <= ~ab; // stale byte must not be trusted
  endtask
  task data(input logic [7:0] d);
    repeat (gap + 1) @(posedge clk);
    rx_data <= d;
    byte_done <= 1'h1;
    @(posedge clk);
    byte_done <= 1'h0;
  endtask
  task stop();
    repeat (gap + 1) @(posedge clk);
    stop_det <= 1'h1;
    @(posedge clk);
    stop_det <= 1'h0;
  endtask
  task lose();
    repeat (gap + 1) @(posedge clk);
    arb_lost <= 1'h1;
    @(posedge clk);
    arb_lost <= 1'h0;
  endtask
endmodule

// ### sim/tb_i2c_status_flag_logic.sv
/*
  testbench: register accesses against bus events from the far side.
  assumes the cfg header map and one-cycle read latency.
*/
`timescale 1ns/100ps
`include "i2c_flag_cfg.svh"
module tb_i2c_status_flag_logic;
  logic clk, arst_n, wr_stb, rd_stb, byte_done, addr_valid, start_det;
  logic stop_det, arb_lost, tx_load, addressed, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, tx_data, addr_byte, rx_data;
  int failures = 0;
  int samples_checked = 0;
  logic [6:0] cal [5] = '{7'h40, 7'h00, 7'h33, 7'h0c, 7'h35};
  int enb [5] = '{0, 1, 2, 3, 0};
  i2c_status_flag_logic i2c_status_flag_logic_inst (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .byte_done(byte_done), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .start_det(start_det), .stop_det(stop_det), .arb_lost(arb_lost),
    .rx_data(rx_data), .tx_data(tx_data), .tx_load(tx_load),
    .addressed(addressed), .irq(irq));
  bus_side bus_side_inst (.clk(clk), .byte_done(byte_done), .addr_valid(addr_valid),
    .addr_byte(addr_byte), .start_det(start_det), .stop_det(stop_det),
    .arb_lost(arb_lost), .rx_data(rx_data));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task finish_test();
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1 chk(rdata & m, e);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    arst_n = 1'h0;
    addr = 4'h0;
    wdata = 8'h00;
    {wr_stb, rd_stb} = 2'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    rd(`STATUS_IDX, 8'hff, 8'h00);
    rd(4'hf, 8'hff, 8'h00);
    wr(`PRIMARY_ADDR_IDX, 8'h54);
    wr(`RANGE_ADDR_IDX, 8'h80);
    wr(`SECOND_ADDR_IDX, 8'h66);
    bus_side_inst.frame(8'h55);
    #1 chk({7'h00, addressed}, 8'h01);
    rd(`STATUS_IDX, 8'h24, 8'h24);
    wr(`CTRL_ONE_IDX, 8'h10);
    #1 chk({7'h00, addressed}, 8'h00);
    bus_side_inst.gap = 2; // slow bus from here on
    for (int i = 0; i < 5; i++) begin
      wr(`ENABLES_IDX, 8'h00);
      bus_side_inst.frame({cal[i], 1'h0});
      #1 chk({7'h00, addressed}, 8'h00);
      wr(`ENABLES_IDX, 8'h01 << enb[i]);
      bus_side_inst.frame({cal[i], 1'h0});
      #1 chk({7'h00, addressed}, 8'h01);
      rd(`STATUS_IDX, 8'h0c, (i % 4 == 0) ? 8'h08 : 8'h00);
      wr(`CTRL_ONE_IDX, 8'h00);
      rd(`STATUS_IDX, 8'h48, 8'h00);
    end
    bus_side_inst.stop();
    rd(`STATUS_IDX, 8'h20, 8'h00);
    bus_side_inst.data(8'h5a);
    rd(`STATUS_IDX, 8'h80, 8'h80);
    wr(`STATUS_IDX, 8'h00);
    rd(`STATUS_IDX, 8'hff, 8'h80);
    rd(`DATA_IDX, 8'hff, 8'h5a);
    rd(`STATUS_IDX, 8'h80, 8'h00);
    wr(`CTRL_ONE_IDX, 8'h10);
    bus_side_inst.data(8'h11);
    rd(`DATA_IDX, 8'hff, 8'h11);
    rd(`STATUS_IDX, 8'h80, 8'h80);
    wr(`DATA_IDX, 8'ha5);
    #1 chk(tx_data, 8'ha5);
    rd(`STATUS_IDX, 8'h80, 8'h00);
    wr(`IRQ_STATUS_IDX, 8'h0f);
    bus_side_inst.lose();
    rd(`STATUS_IDX, 8'h10, 8'h10);
    rd(`IRQ_STATUS_IDX, 8'hff, 8'h04);
    chk({7'h00, irq}, 8'h00);
    wr(`IRQ_MASK_IDX, 8'h04);
    #1 chk({7'h00, irq}, 8'h01);
    wr(`STATUS_IDX, 8'hef);
    rd(`STATUS_IDX, 8'hff, 8'h10);
    wr(`STATUS_IDX, 8'h10);
    rd(`STATUS_IDX, 8'h10, 8'h00);
    wr(`IRQ_STATUS_IDX, 8'h04);
    #1 chk({7'h00, irq}, 8'h00);
    finish_test();
  end
endmodule
